/* File: logic/isr_map.svh */
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
`define ISR_DEV_ADDR 7'h68
`define ISR_PTR_RST 8'h00
`define ISR_RW_BIT 0
`define ISR_MSB 7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ISR_SYS_PERIOD_NS 40
`define ISR_SCL_PERIOD_NS 2500
`define ISR_QTR_CYC ((`ISR_SCL_PERIOD_NS / 4 + `ISR_SYS_PERIOD_NS - 1) / `ISR_SYS_PERIOD_NS)
`define ISR_BITS_PER_BYTE 8

`endif

/* File: logic/isr_pkg.sv */
package isr_pkg;

  // ----------------------------------------------------------------
  // device end
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_RX = 3'h1,
    DS_RX_ACK = 3'h2,
    DS_TX = 3'h3,
    DS_TX_ACK = 3'h4
  } isr_dst_t;

  typedef enum logic [1:0] {
    BK_ADDR = 2'h0,
    BK_PTR = 2'h1,
    BK_DATA = 2'h2
  } isr_kind_t;

  // ----------------------------------------------------------------
  // host end
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_HOLD = 3'h1,
    HS_START = 3'h2,
    HS_BIT = 3'h3,
    HS_STOP = 3'h4
  } isr_hst_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } isr_cmd_t;

endpackage : isr_pkg

/* File: logic/isr_link_if.sv */
`timescale 1ns/100ps

interface isr_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;

  // wired-and of both open-drain drivers, pulled high when nobody drives
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

  modport dev (
    input scl,
    input sda,
    output d_sda_o,
    output d_sda_oe_n
  );

  modport host (
    output scl,
    input sda,
    output m_sda_o,
    output m_sda_oe_n
  );
endinterface : isr_link_if

/* File: logic/isr_dev.sv */
// Notes on behaviour
// R1: acknowledge every received byte once addressed
// R2: master adds ninth clock for acknowledge
// R3: acknowledger holds data low through clock high
// R4: master acks read bytes, nacks last
// R5: release data line after master nack
// R6: first byte after start is address
// R7: address lsb zero writes, one reads
// R8: acknowledge a matching address either direction
// R9: first write byte loads register pointer
// R10: data bytes stored at pointer, pointer increments
// R11: master ends write with stop
// R12: read starts at current pointer register
// R13: without pointer write, pointer is retained
// R14: keep sending bytes until master nack
// R15: every byte travels msb first
// R16: repeated start begins a new transfer
// R17: start and stop reframe byte counting
// R18: master makes all clocks, starts, stops
// R19: start/stop are data edges while clock high
// R20: data changes only while clock low
// R21: on mismatch stay released until start
`timescale 1ns/100ps
`include "isr_map.svh"

module isr_dev (
  // system side
  input wire logic sys_clk,
  input wire logic rstn,
  // link clock, oversamples the bus
  input wire logic link_clk,
  // register write strobe
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // register read request, data is taken one cycle after rd_stb
  output logic rd_stb,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // bus
  isr_link_if.dev link
);
  import isr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    isr_dst_t st;
    isr_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic req_tgl;
    logic req_wr;
    logic [7:0] req_addr;
    logic [7:0] req_data;
    logic ack_m;
    logic ack_s;
    logic ack_p;
    logic [7:0] fetch;
  } isr_dlink_t;

  typedef struct packed {
    logic tg_m;
    logic tg_s;
    logic tg_p;
    logic pend;
    logic ack_tgl;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_stb;
    logic [7:0] rd_addr;
    logic [7:0] rd_hold;
  } isr_dsys_t;

  isr_dlink_t lk_r;
  isr_dlink_t lk_nxt;
  isr_dsys_t sy_r;
  isr_dsys_t sy_nxt;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;

  // ----------------------------------------------------------------
  // bus conditions, seen only through the synchronised copies
  // ----------------------------------------------------------------
  assign scl_rise = ~lk_r.scl_p & lk_r.scl_s;
  assign scl_fall = lk_r.scl_p & ~lk_r.scl_s;
  assign bus_start = lk_r.scl_p & lk_r.scl_s & lk_r.sda_p & ~lk_r.sda_s;  // [R19]
  assign bus_stop = lk_r.scl_p & lk_r.scl_s & ~lk_r.sda_p & lk_r.sda_s;  // [R19]
  assign byte_done = (lk_r.cnt == 4'(`ISR_BITS_PER_BYTE));

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  always_comb
  begin
    lk_nxt = lk_r;
    lk_nxt.scl_m = link.scl;
    lk_nxt.scl_s = lk_r.scl_m;
    lk_nxt.scl_p = lk_r.scl_s;
    lk_nxt.sda_m = link.sda;
    lk_nxt.sda_s = lk_r.sda_m;
    lk_nxt.sda_p = lk_r.sda_s;
    lk_nxt.ack_m = sy_r.ack_tgl;
    lk_nxt.ack_s = lk_r.ack_m;
    lk_nxt.ack_p = lk_r.ack_s;
    // read data is loaded by the system side on the same edge its toggle flips, then held stable
    if (lk_r.ack_s != lk_r.ack_p)
    begin
      lk_nxt.fetch = sy_r.rd_hold;
    end
    if (bus_start)
    begin
      // a repeated start simply reframes, whatever was going on
      lk_nxt.st = DS_RX;  // [R16] [R17]
      lk_nxt.kind = BK_ADDR;  // [R6]
      lk_nxt.cnt = 4'h0;
      lk_nxt.sda_oe_n = 1'b1;
    end
    else if (bus_stop)
    begin
      lk_nxt.st = DS_IDLE;  // [R17]
      lk_nxt.sda_oe_n = 1'b1;
    end
    else
    begin
      unique case (lk_r.st)
        DS_IDLE:
        begin
          lk_nxt.sda_oe_n = 1'b1;  // [R21]
        end
        DS_RX:
        begin
          if (scl_rise)
          begin
            // sampled only after clock high is seen, data is stable then
            lk_nxt.sh = {lk_r.sh[6:0], lk_r.sda_s};  // [R15] [R20]
            lk_nxt.cnt = lk_r.cnt + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            lk_nxt.st = DS_RX_ACK;
            lk_nxt.sda_oe_n = 1'b0;  // [R1]
            unique case (lk_r.kind)
              BK_ADDR:
              begin
                if (lk_r.sh[7:1] == `ISR_DEV_ADDR)
                begin
                  lk_nxt.rw = lk_r.sh[`ISR_RW_BIT];  // [R7] [R8]
                  if (lk_r.sh[`ISR_RW_BIT])
                  begin
                    // prefetch from the retained pointer during the ack bit
                    lk_nxt.req_tgl = ~lk_r.req_tgl;  // [R12] [R13]
                    lk_nxt.req_wr = 1'b0;
                    lk_nxt.req_addr = lk_r.ptr;
                  end
                end
                else
                begin
                  lk_nxt.st = DS_IDLE;  // [R21]
                  lk_nxt.sda_oe_n = 1'b1;
                end
              end
              BK_PTR:
              begin
                lk_nxt.ptr = lk_r.sh;  // [R9]
              end
              default:
              begin
                lk_nxt.req_tgl = ~lk_r.req_tgl;  // [R10]
                lk_nxt.req_wr = 1'b1;
                lk_nxt.req_addr = lk_r.ptr;
                lk_nxt.req_data = lk_r.sh;
                lk_nxt.ptr = lk_r.ptr + 8'h01;  // [R10]
              end
            endcase
          end
        end
        DS_RX_ACK:
        begin
          // released only after clock low is seen
          if (scl_fall)
          begin
            lk_nxt.sda_oe_n = 1'b1;  // [R3]
            lk_nxt.cnt = 4'h0;
            if (lk_r.kind == BK_ADDR && lk_r.rw)
            begin
              lk_nxt.st = DS_TX;
              lk_nxt.sh = lk_r.fetch;
              lk_nxt.sda_oe_n = lk_r.fetch[`ISR_MSB];  // [R15]
              lk_nxt.ptr = lk_r.ptr + 8'h01;
            end
            else
            begin
              lk_nxt.st = DS_RX;
              lk_nxt.kind = (lk_r.kind == BK_ADDR) ? BK_PTR : BK_DATA;
            end
          end
        end
        DS_TX:
        begin
          if (scl_fall)
          begin
            if (lk_r.cnt == 4'(`ISR_BITS_PER_BYTE - 1))
            begin
              lk_nxt.st = DS_TX_ACK;
              lk_nxt.sda_oe_n = 1'b1;
              lk_nxt.req_tgl = ~lk_r.req_tgl;  // [R14]
              lk_nxt.req_wr = 1'b0;
              lk_nxt.req_addr = lk_r.ptr;
            end
            else
            begin
              lk_nxt.cnt = lk_r.cnt + 4'h1;
              lk_nxt.sh = {lk_r.sh[6:0], 1'b0};
              lk_nxt.sda_oe_n = lk_r.sh[6];  // [R15] [R20]
            end
          end
        end
        DS_TX_ACK:
        begin
          if (scl_rise)
          begin
            lk_nxt.mack = lk_r.sda_s;
          end
          else if (scl_fall)
          begin
            if (!lk_r.mack)
            begin
              lk_nxt.st = DS_TX;  // [R14]
              lk_nxt.cnt = 4'h0;
              lk_nxt.sh = lk_r.fetch;
              lk_nxt.sda_oe_n = lk_r.fetch[`ISR_MSB];
              lk_nxt.ptr = lk_r.ptr + 8'h01;
            end
            else
            begin
              // line left high so the master can place its stop
              lk_nxt.st = DS_IDLE;  // [R5]
              lk_nxt.sda_oe_n = 1'b1;
            end
          end
        end
        default:
        begin
          lk_nxt.st = DS_IDLE;
          lk_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lk_r <= '0;
      lk_r.scl_m <= 1'b1;
      lk_r.scl_s <= 1'b1;
      lk_r.scl_p <= 1'b1;
      lk_r.sda_m <= 1'b1;
      lk_r.sda_s <= 1'b1;
      lk_r.sda_p <= 1'b1;
      lk_r.mack <= 1'b1;
      lk_r.sda_oe_n <= 1'b1;
      lk_r.ptr <= `ISR_PTR_RST;
    end
    else
    begin
      lk_r <= lk_nxt;
    end
  end

  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe_n = lk_r.sda_oe_n;

  // ----------------------------------------------------------------
  // system domain
  // ----------------------------------------------------------------
  always_comb
  begin
    sy_nxt = sy_r;
    sy_nxt.tg_m = lk_r.req_tgl;
    sy_nxt.tg_s = sy_r.tg_m;
    sy_nxt.tg_p = sy_r.tg_s;
    sy_nxt.wr_stb = 1'b0;
    sy_nxt.rd_stb = 1'b0;
    if (sy_r.pend)
    begin
      sy_nxt.rd_hold = rd_data;
      sy_nxt.ack_tgl = ~sy_r.ack_tgl;
      sy_nxt.pend = 1'b0;
    end
    // request fields stay frozen for a whole bit time after their toggle
    if (sy_r.tg_s != sy_r.tg_p)
    begin
      if (lk_r.req_wr)
      begin
        sy_nxt.wr_stb = 1'b1;
        sy_nxt.wr_addr = lk_r.req_addr;
        sy_nxt.wr_data = lk_r.req_data;
      end
      else
      begin
        sy_nxt.rd_stb = 1'b1;
        sy_nxt.rd_addr = lk_r.req_addr;
        sy_nxt.pend = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sy_r <= '0;
    end
    else
    begin
      sy_r <= sy_nxt;
    end
  end

  assign wr_stb = sy_r.wr_stb;
  assign wr_addr = sy_r.wr_addr;
  assign wr_data = sy_r.wr_data;
  assign rd_stb = sy_r.rd_stb;
  assign rd_addr = sy_r.rd_addr;

endmodule : isr_dev

/* File: logic/isr_host.sv */
`timescale 1ns/100ps
`include "isr_map.svh"

module isr_host (
  // system side
  input wire logic sys_clk,
  input wire logic rstn,
  // commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire isr_pkg::isr_cmd_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  // byte results
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  // bus
  isr_link_if.host link
);
  import isr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    isr_hst_t st;
    logic [1:0] q;
    logic [4:0] tick;
    logic [3:0] nbit;
    logic [8:0] tx;
    logic [8:0] rx;
    logic scl;
    logic sda_oe_n;
    logic sda_m;
    logic sda_s;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
  } isr_host_t;

  isr_host_t hs_r;
  isr_host_t hs_nxt;
  logic qend;
  logic take;

  assign qend = (hs_r.tick == 5'(`ISR_QTR_CYC - 1));
  assign cmd_ready = (hs_r.st == HS_IDLE) || (hs_r.st == HS_HOLD);
  assign take = cmd_valid & cmd_ready;

  // ----------------------------------------------------------------
  // bit engine, four quarters per clock; data moves one quarter after scl
  // falls so the slave never sees it move together with the clock
  // ----------------------------------------------------------------
  always_comb
  begin
    hs_nxt = hs_r;
    hs_nxt.sda_m = link.sda;
    hs_nxt.sda_s = hs_r.sda_m;
    hs_nxt.rsp_valid = 1'b0;
    if (hs_r.st != HS_IDLE && hs_r.st != HS_HOLD)
    begin
      hs_nxt.tick = qend ? 5'h00 : hs_r.tick + 5'h01;
      hs_nxt.q = qend ? hs_r.q + 2'h1 : hs_r.q;
    end
    unique case (hs_r.st)
      HS_IDLE, HS_HOLD:
      begin
        hs_nxt.tick = 5'h00;
        hs_nxt.q = 2'h0;
        if (take)
        begin
          hs_nxt.scl = 1'b0;
          hs_nxt.nbit = 4'h0;
          hs_nxt.st = HS_START;
          if (hs_r.st == HS_HOLD && cmd_op == CMD_STOP)
          begin
            hs_nxt.st = HS_STOP;
          end
          else if (hs_r.st == HS_HOLD && cmd_op == CMD_WRITE)
          begin
            hs_nxt.st = HS_BIT;
            hs_nxt.tx = {cmd_data, 1'b1};
          end
          else if (hs_r.st == HS_HOLD && cmd_op == CMD_READ)
          begin
            hs_nxt.st = HS_BIT;
            hs_nxt.tx = {8'hff, cmd_nack};  // [R4]
          end
          else if (cmd_op != CMD_START)
          begin
            // data or stop with the bus free is dropped
            hs_nxt.st = HS_IDLE;
            hs_nxt.scl = 1'b1;
          end
        end
      end
      HS_START:
      begin
        if (qend)
        begin
          unique case (hs_r.q)
            2'h0: hs_nxt.sda_oe_n = 1'b1;
            2'h1: hs_nxt.scl = 1'b1;
            2'h2: hs_nxt.sda_oe_n = 1'b0;  // [R18] [R19]
            2'h3:
            begin
              hs_nxt.scl = 1'b0;
              hs_nxt.st = HS_HOLD;
            end
          endcase
        end
      end
      HS_STOP:
      begin
        if (qend)
        begin
          unique case (hs_r.q)
            2'h0: hs_nxt.sda_oe_n = 1'b0;
            2'h1: hs_nxt.scl = 1'b1;
            2'h2: hs_nxt.sda_oe_n = 1'b1;  // [R11] [R19]
            2'h3: hs_nxt.st = HS_IDLE;
          endcase
        end
      end
      HS_BIT:
      begin
        if (qend)
        begin
          unique case (hs_r.q)
            2'h0: hs_nxt.sda_oe_n = hs_r.tx[8];  // [R15] [R20] [R3]
            2'h1: hs_nxt.scl = 1'b1;  // [R2] [R18]
            2'h2: hs_nxt.scl = 1'b1;
            2'h3:
            begin
              hs_nxt.rx = {hs_r.rx[7:0], hs_r.sda_s};
              hs_nxt.scl = 1'b0;
              if (hs_r.nbit == 4'(`ISR_BITS_PER_BYTE))
              begin
                // data line kept as is: releasing now would race the clock edge
                hs_nxt.st = HS_HOLD;
                hs_nxt.rsp_valid = 1'b1;
                hs_nxt.rsp_data = hs_r.rx[7:0];
                hs_nxt.rsp_nack = hs_r.sda_s;
              end
              else
              begin
                hs_nxt.nbit = hs_r.nbit + 4'h1;
                hs_nxt.tx = {hs_r.tx[7:0], 1'b1};
              end
            end
          endcase
        end
      end
      default:
      begin
        hs_nxt.st = HS_IDLE;
        hs_nxt.scl = 1'b1;
        hs_nxt.sda_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hs_r <= '0;
      hs_r.scl <= 1'b1;
      hs_r.sda_oe_n <= 1'b1;
      hs_r.sda_m <= 1'b1;
      hs_r.sda_s <= 1'b1;
    end
    else
    begin
      hs_r <= hs_nxt;
    end
  end

  assign link.scl = hs_r.scl;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe_n = hs_r.sda_oe_n;
  assign rsp_valid = hs_r.rsp_valid;
  assign rsp_data = hs_r.rsp_data;
  assign rsp_nack = hs_r.rsp_nack;

endmodule : isr_host

/* File: sim/isr_monitor.sv */
`timescale 1ns/100ps
`include "isr_map.svh"

module isr_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // wire
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_oe_n
);
  // ----------------------------------------------------------------
  // frame tracking, oversampled on the system clock
  // ----------------------------------------------------------------
  logic scl_r, sda_r, mt_r, rw_r, dead_r, rel_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [1:0] byten_r;
  logic hi, rise, start, stop;

  assign hi = scl & scl_r;
  assign rise = scl & ~scl_r;
  assign start = hi & sda_r & ~sda;
  assign stop = hi & ~sda_r & sda;

  // cnt_r is the number of clock rises since start or since the last ack slot; 9 marks the ack slot
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      byten_r <= 2'h0;
      mt_r <= 1'b0;
      rw_r <= 1'b0;
      dead_r <= 1'b0;
      rel_r <= 1'b0;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      if (start | stop)
      begin
        cnt_r <= 4'h0;
        byten_r <= 2'h0;
        mt_r <= 1'b0;
        dead_r <= 1'b0;
        rel_r <= 1'b0;
      end
      else if (rise)
      begin
        cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
        if (cnt_r < 4'h8)
          sh_r <= {sh_r[6:0], sda};
        if (cnt_r == 4'h9)
          byten_r <= (byten_r == 2'h3) ? 2'h3 : byten_r + 2'h1;
        if (cnt_r == 4'h8 && byten_r == 2'h0)
        begin
          mt_r <= (sh_r[7:1] == `ISR_DEV_ADDR);
          rw_r <= sh_r[0];
          dead_r <= (sh_r[7:1] != `ISR_DEV_ADDR);
        end
        if (cnt_r == 4'h8 && byten_r != 2'h0 && mt_r && rw_r && sda)
          rel_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  chk_dev_sda_steady: assert property (hi |-> d_sda_oe_n == $past(d_sda_oe_n))
    else $error("device data drive changed while clock high");
  chk_addr_ack: assert property (hi && cnt_r == 4'h9 && byten_r == 2'h0 &&
    sh_r[7:1] == `ISR_DEV_ADDR |-> !d_sda_oe_n) else $error("matching address not acked");
  chk_addr_nomatch: assert property (hi && cnt_r == 4'h9 && byten_r == 2'h0 &&
    sh_r[7:1] != `ISR_DEV_ADDR |-> d_sda_oe_n) else $error("foreign address acked");
  chk_quiet_after_miss: assert property (dead_r |-> d_sda_oe_n)
    else $error("device drove after address mismatch");
  chk_write_byte_ack: assert property (hi && cnt_r == 4'h9 && byten_r != 2'h0 &&
    mt_r && !rw_r |-> !d_sda_oe_n) else $error("received byte not acked");
  chk_read_ack_slot: assert property (hi && cnt_r == 4'h9 && byten_r != 2'h0 &&
    mt_r && rw_r |-> d_sda_oe_n) else $error("device drove in master ack slot");
  // once the master has sent its nack it may pull low to set up the stop
  chk_read_dir_free: assert property (hi && cnt_r != 4'h0 && cnt_r < 4'h9 &&
    byten_r != 2'h0 && mt_r && rw_r && !rel_r |-> m_sda_oe_n)
    else $error("master drove read data");
  chk_nack_release: assert property (rel_r |-> d_sda_oe_n)
    else $error("device drove after master nack");
  chk_stop_bus_free: assert property (stop |=> scl [*8])
    else $error("clock left high state right after stop");
endmodule : isr_monitor

/* File: sim/tb_i2c_slave_register_port.sv */
`timescale 1ns/100ps
`include "isr_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_i2c_slave_register_port;
  import isr_pkg::*;
  // ----------------------------------------------------------------
  // signals and register memory
  // ----------------------------------------------------------------
  logic sys_clk, link_clk, rstn;
  logic cmd_valid, cmd_ready, cmd_nack, rsp_valid, rsp_nack, wr_stb, rd_stb;
  isr_cmd_t cmd_op;
  logic [7:0] cmd_data, rsp_data, wr_addr, wr_data, rd_addr, rd_data, p, a, d;
  logic [7:0] mem [256];
  logic [7:0] shd [256];
  logic [8:0] rq [$];
  logic [15:0] wq [$];
  logic [8:0] e9;
  logic [15:0] e16;
  integer seed = 32'hff713d61;
  int n_fail, tests_run, n_rd;

  isr_link_if link ();
  isr_host u_isr_host (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .link(link));
  isr_dev u_isr_dev (.sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_stb(rd_stb), .rd_addr(rd_addr),
    .rd_data(rd_data), .link(link));
  isr_monitor u_isr_monitor (.sys_clk(sys_clk), .rstn(rstn), .scl(link.scl), .sda(link.sda),
    .m_sda_oe_n(link.m_sda_oe_n), .d_sda_oe_n(link.d_sda_oe_n));

  // combinational read path so the data is valid whichever edge the device samples
  assign rd_data = mem[rd_addr];

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  // ----------------------------------------------------------------
  // result watcher
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      e9 = rq.size() ? rq.pop_front() : 9'hx;
      `CHK("rsp", e9, {rsp_data, rsp_nack})
    end
    if (wr_stb === 1'b1)
    begin
      e16 = wq.size() ? wq.pop_front() : 16'hxxxx;
      `CHK("wr", e16, {wr_addr, wr_data})
      mem[wr_addr] <= wr_data;
    end
    if (rd_stb === 1'b1)
    begin
      n_rd++;
    end
  end

  task automatic cmd(input isr_cmd_t op, input logic [7:0] b, input logic nk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= b;
    cmd_nack <= nk;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1) @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1) @(posedge sys_clk);
  endtask : cmd

  task automatic wb(input logic [7:0] b, input logic nk);
    rq.push_back({b, nk});
    cmd(CMD_WRITE, b, 1'b0);
  endtask : wb

  task automatic rb(input logic [7:0] ad, input logic nk);
    rq.push_back({shd[ad], nk});
    cmd(CMD_READ, 8'h00, nk);
  endtask : rb

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  initial
  begin
    #1500000;
    n_fail++;
    close_out();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = CMD_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    n_fail = 0;
    tests_run = 0;
    n_rd = 0;
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'(i) ^ 8'ha5;
      shd[i] = 8'(i) ^ 8'ha5;
    end
    repeat (3) @(posedge link_clk);
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge link_clk);
    @(posedge sys_clk);
    p = $random(seed);
    // a byte command with the bus free must be dropped without any result
    cmd(CMD_WRITE, 8'h00, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    wb({`ISR_DEV_ADDR, 1'b0}, 1'b0);
    wb(p, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      d = $random(seed);
      wq.push_back({p + 8'(i), d});
      shd[p + 8'(i)] = d;
      wb(d, 1'b0);
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test write_burst done");
    cmd(CMD_START, 8'h00, 1'b0);
    wb({`ISR_DEV_ADDR, 1'b1}, 1'b0);
    rb(p + 8'h3, 1'b0);
    rb(p + 8'h4, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test retained_read done");
    for (int i = 0; i < 3; i++)
    begin
      a = $random(seed);
      a[0] = i[0];
      if (a[7:1] == `ISR_DEV_ADDR)
        a[7] = ~a[7];
      cmd(CMD_START, 8'h00, 1'b0);
      wb(a, 1'b1);
      if (a[0])
      begin
        rq.push_back({8'hff, 1'b1});
        cmd(CMD_READ, 8'h00, 1'b1);
      end
      else
        wb(8'h5a, 1'b1);
      cmd(CMD_STOP, 8'h00, 1'b0);
    end
    $display("test foreign_address done");
    cmd(CMD_START, 8'h00, 1'b0);
    wb({`ISR_DEV_ADDR, 1'b0}, 1'b0);
    wb(p, 1'b0);
    cmd(CMD_START, 8'h00, 1'b0);
    wb({`ISR_DEV_ADDR, 1'b1}, 1'b0);
    rb(p, 1'b0);
    rb(p + 8'h1, 1'b0);
    rb(p + 8'h2, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test repeated_start done");
    repeat (200) @(posedge sys_clk);
    `CHK("queues", 0, rq.size() + wq.size())
    `CHK("reads", 7, n_rd)
    `CHK("rd_addr", p + 8'h3, rd_addr)
    close_out();
  end
endmodule : tb_i2c_slave_register_port
